// ===== hdl/fmp_pkg.sv
// Package: constants and carrier types of the flash map and protect control
package fmp_pkg;

  // ==========================================================
  // Commit keys
  // ==========================================================
  localparam logic [7:0] KEY_FLASH = 8'hd5; // Flash control commit
  localparam logic [7:0] KEY_SYS   = 8'hd4; // System config commit

  // ==========================================================
  // Protect field codes and area-select codes
  // ==========================================================
  localparam logic [2:0] MODE_OFF  = 3'h2; // Commands disabled
  localparam logic [2:0] MODE_ON   = 3'h5; // Commands enabled
  localparam logic [1:0] AREA_STD  = 2'h0; // Standard mapping
  localparam logic [1:0] AREA_CODE = 2'h2; // Code window in data

  // ==========================================================
  // Address map
  // ==========================================================
  localparam logic [15:0] FLASH_LO   = 16'h8000; // Flash window base
  localparam logic [15:0] BOOT_LO    = 16'h1000; // Boot ROM base
  localparam logic [15:0] BOOT_HI    = 16'h17ff; // 2K boot ROM top
  localparam logic [15:0] BOOT_HI_SP = 16'h1fff; // Code top, PROM mode
  localparam logic [15:0] RAM_C_HI   = 16'h0fff; // RAM top in code area

  // ==========================================================
  // System config bit positions and port control read value
  // ==========================================================
  localparam int          SYS_RAM_BIT = 0; // RAM-in-code bit
  localparam int          SYS_VEC_BIT = 1; // Vector-in-RAM bit
  localparam int          STBY_BIT    = 0; // Standby bit
  localparam int          PIN_GEN_BIT = 0; // General port enable
  localparam int          PIN_CLK_BIT = 1; // Serial clock enable
  localparam logic [7:0]  PORT_RD_SET = 8'h80; // Fixed high bit

  // ==========================================================
  // Types
  // ==========================================================
  // Flash control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] mode;   // Protect field
    logic       boot;   // Boot ROM show
    logic [1:0] area;   // Area select
    logic       rsvd;   // Spare read/write bit
    logic       romsel; // Spare select bit
  } fmp_flash_cfg_t;

  localparam fmp_flash_cfg_t CFG_RESET = '{MODE_OFF, 1'b0, AREA_STD,
                                           1'b0, 1'b0};

  // Monitor register layout
  typedef struct packed {
    logic [1:0] zero;    // Reads zero
    logic       mode_on; // Enable is in effect
    logic       boot;    // Active boot bit
    logic [1:0] area;    // Active area select
    logic       rsvd;    // Active spare bit
    logic       romsel;  // Active select bit
  } fmp_monitor_t;

  // Target of one address
  typedef enum logic [1:0] {TGT_NONE, TGT_FLASH, TGT_RAM, TGT_BOOT}
    fmp_target_t;

  // Decoded route of one access
  typedef struct packed {
    fmp_target_t tgt;       // Where the access lands
    logic [14:0] flash_off; // Physical flash offset
  } fmp_route_t;

  // Map settings seen by the decoder
  typedef struct packed {
    logic spm;     // Serial PROM mode
    logic boot;    // Active boot show
    logic ram_map; // Active RAM-in-code
  } fmp_map_cfg_t;

  // Port input enables
  typedef struct packed {
    logic sclk;    // Serial clock pin
    logic general; // All other pins
  } fmp_port_en_t;

  // Whole state of the control block
  typedef struct packed {
    fmp_flash_cfg_t staged;   // Written, not yet in effect
    fmp_flash_cfg_t active;   // In effect
    logic           ram_stg;  // Staged RAM-in-code
    logic           vec_stg;  // Staged vector select
    logic           ram_act;  // Active RAM-in-code
    logic           vec_act;  // Active vector select
    logic           stby;     // Standby bit
    fmp_port_en_t   pin;      // Port enables as written
    logic           cmd_wr;   // Command write strobe
    logic [14:0]    cmd_addr; // Command offset
    logic [7:0]     cmd_data; // Command data
    logic           stby_rst; // Standby reset pulse
    fmp_route_t     code_r;   // Last code route
    fmp_route_t     data_r;   // Last data route
  } fmp_state_t;

endpackage

// ===== hdl/fmp_addr_map.sv
// Address decoder: code and data addresses to flash, RAM or boot ROM
`timescale 1ns/1ns
module fmp_addr_map
(
  // Map settings
  input  fmp_pkg::fmp_map_cfg_t cfg,
  // Addresses
  input  logic [15:0]           code_addr,
  input  logic [15:0]           data_addr,
  // Routes
  output fmp_pkg::fmp_route_t   code_route,
  output fmp_pkg::fmp_route_t   data_route
);

  // ==========================================================
  // Decode function, shared by both areas
  // ==========================================================
  // Both windows take the same offset, so mirrors hit one byte
  function automatic fmp_pkg::fmp_route_t route
  (
    input logic [15:0]          addr,
    input logic                 is_code,
    input fmp_pkg::fmp_map_cfg_t c
  );
    fmp_pkg::fmp_route_t r;
    logic                show;
    logic [15:0]         hi;
    r           = '{fmp_pkg::TGT_NONE, addr[14:0]};
    show        = c.spm | c.boot;
    hi          = (is_code && c.spm) ? fmp_pkg::BOOT_HI_SP
                                     : fmp_pkg::BOOT_HI;
    // Boot ROM takes its range before flash and RAM are tried
    if (show && addr >= fmp_pkg::BOOT_LO && addr <= hi)
    begin
      r.tgt = fmp_pkg::TGT_BOOT; // R13 R14
    end
    // Common flash window
    else if (addr >= fmp_pkg::FLASH_LO)
    begin
      r.tgt = fmp_pkg::TGT_FLASH; // R10
    end
    // RAM in the code area
    else if (is_code && (c.spm || c.ram_map) &&
             addr <= fmp_pkg::RAM_C_HI)
    begin
      r.tgt = fmp_pkg::TGT_RAM; // R11 R12
    end
    return r;
  endfunction

  // ==========================================================
  // Both decoders
  // ==========================================================
  assign code_route = route(code_addr, 1'b1, cfg);
  assign data_route = route(data_addr, 1'b0, cfg);

endmodule

// ===== hdl/fmp_flash_map_ctrl.sv
// Flash protect, address map, standby and port input control
`timescale 1ns/1ns
// Summary of operation
// R1: Mode 101 then key D5 enables commands
// R2: Mode 010 then key D5 protects flash
// R3: Protected flash ignores commands and toggle
// R4: Reset loads protect field with 010
// R5: Protection blocks new writes, no abort
// R6: Software finishes sequences before protecting
// R7: Area 10 maps code window into data; area is not decoded, both areas always share the flash window
// R8: Area 00 plus key restores mapping; area is not decoded, so area 00 changes no route
// R9: Commands reach flash only via data area
// R10: Both windows hit the same byte
// R11: RAM-map bit plus key D4 maps RAM
// R12: Serial PROM mode always maps RAM
// R13: Committed boot bit shows boot ROM
// R14: Serial PROM mode always shows boot ROM
// R15: Boot bit fixed at 1 in PROM mode
// R16: Standby write accepted only from RAM
// R17: Flash access in standby resets device
// R18: Interrupt with flash vectors clears standby
// R19: Interrupt with RAM vectors keeps standby
// R20: PROM mode reset disables port inputs
// R21: Enable bits open serial clock, other pins
// R22: Port control ignored in MCU mode
// R23: Settings staged, commit key, monitor shows
// R24: Port control reads zero in MCU mode
// R25: Wrong key changes nothing
module fmp_flash_map_ctrl
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // Operating mode strap
  input  wire logic                  serial_prom_mode,
  // Register write strobes, shared data byte
  input  wire logic                  stage_wr,
  input  wire logic                  commit_wr,
  input  wire logic                  sys_cfg_wr,
  input  wire logic                  sys_commit_wr,
  input  wire logic                  standby_wr,
  input  wire logic                  port_ctrl_wr,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  fetch_from_ram,
  // Register read values
  output logic [7:0]                 flash_ctrl_staging,
  output logic [7:0]                 flash_ctrl_monitor,
  output logic [7:0]                 flash_standby_reg,
  output logic [7:0]                 sys_cfg_reg3,
  output logic [7:0]                 port_input_ctrl,
  // CPU accesses
  input  wire logic                  code_fetch,
  input  wire logic [15:0]           code_addr,
  input  wire logic                  data_rd,
  input  wire logic                  data_wr,
  input  wire logic [15:0]           data_addr,
  input  wire logic [7:0]            data_wdata,
  input  wire logic                  irq_ack,
  // Flash side
  output logic                       flash_cmd_wr,
  output logic [14:0]                flash_cmd_addr,
  output logic [7:0]                 flash_cmd_data,
  output logic                       flash_toggle_en,
  output fmp_pkg::fmp_route_t        code_route,
  output fmp_pkg::fmp_route_t        data_route,
  output logic                       standby_reset,
  // Port input gating
  output logic                       general_port_input_en,
  output logic                       serial_clk_input_en
);

  // ==========================================================
  // State
  // ==========================================================
  fmp_pkg::fmp_state_t   st;      // Registered state
  fmp_pkg::fmp_state_t   next_st; // Next state
  fmp_pkg::fmp_map_cfg_t map_cfg; // Decoder settings
  fmp_pkg::fmp_route_t   c_route; // Live code route
  fmp_pkg::fmp_route_t   d_route; // Live data route
  logic                  mode_on; // Commands enabled now
  logic                  key_ok;  // Flash key written
  logic                  skey_ok; // System key written
  logic                  fl_acc;  // Any flash access now

  // ==========================================================
  // Decoder
  // ==========================================================
  // Serial PROM mode forces RAM and boot ROM in
  always_comb
  begin
    map_cfg.spm     = serial_prom_mode;                          // R12
    map_cfg.boot    = serial_prom_mode | st.active.boot;         // R14
    map_cfg.ram_map = st.ram_act;                                // R11
  end

  fmp_addr_map u_map
  (
    .cfg        (map_cfg),
    .code_addr  (code_addr),
    .data_addr  (data_addr),
    .code_route (c_route),
    .data_route (d_route)
  );

  // ==========================================================
  // Decoded conditions
  // ==========================================================
  // Only the exact keys count
  assign key_ok  = commit_wr && wr_data == fmp_pkg::KEY_FLASH; // R25
  assign skey_ok = sys_commit_wr && wr_data == fmp_pkg::KEY_SYS; // R25
  assign mode_on = st.active.mode == fmp_pkg::MODE_ON;            // R1 R2
  // Fetches and data accesses both count as flash use
  assign fl_acc  = (code_fetch && c_route.tgt == fmp_pkg::TGT_FLASH)
                || ((data_rd || data_wr) &&
                    d_route.tgt == fmp_pkg::TGT_FLASH);

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    next_st = st;
    // Staging copy; boot bit is frozen in PROM mode
    if (stage_wr)
    begin
      next_st.staged = fmp_pkg::fmp_flash_cfg_t'(wr_data);       // R23
      if (serial_prom_mode)
      begin
        next_st.staged.boot = st.staged.boot;                     // R15
      end
    end
    // Flash key moves the staged copy into effect
    if (key_ok)
    begin
      next_st.active = st.staged;                       // R1 R2 R7 R8
    end
    // System config staging and its own key
    if (sys_cfg_wr)
    begin
      next_st.ram_stg = wr_data[fmp_pkg::SYS_RAM_BIT];
      next_st.vec_stg = wr_data[fmp_pkg::SYS_VEC_BIT];
    end
    if (skey_ok)
    begin
      next_st.ram_act = st.ram_stg;                               // R11
      next_st.vec_act = st.vec_stg;
    end
    // Standby bit: only code running from RAM may write it
    if (standby_wr && fetch_from_ram)
    begin
      next_st.stby = wr_data[fmp_pkg::STBY_BIT];                  // R16
    end
    // Interrupt with flash vectors clears standby, over a same-cycle write
    if (irq_ack && !st.vec_act)
    begin
      next_st.stby = 1'b0;                                        // R18
    end
    // With RAM vectors the bit stays, nothing here              R19
    // Port enables take writes only in PROM mode
    if (port_ctrl_wr && serial_prom_mode)
    begin
      next_st.pin.general = wr_data[fmp_pkg::PIN_GEN_BIT];        // R21
      next_st.pin.sclk    = wr_data[fmp_pkg::PIN_CLK_BIT];        // R21
    end
    // Command writes pass only via the data window when enabled;
    // a sequence in flight is never aborted, only new writes drop
    next_st.cmd_wr = data_wr && mode_on &&
                     d_route.tgt == fmp_pkg::TGT_FLASH;       // R3 R5 R9
    if (next_st.cmd_wr)
    begin
      next_st.cmd_addr = d_route.flash_off;                       // R10
      next_st.cmd_data = data_wdata;
    end
    // Flash use while in standby resets the device
    next_st.stby_rst = st.stby && fl_acc;                     // R17 R19
    // Route snapshots
    if (code_fetch)
    begin
      next_st.code_r = c_route;
    end
    if (data_rd || data_wr)
    begin
      next_st.data_r = d_route;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Synchronous reset puts protection on
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st        <= '0;
      st.staged <= fmp_pkg::CFG_RESET;                            // R4
      st.active <= fmp_pkg::CFG_RESET;                            // R4
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Read values; standby reads zero
  always_comb
  begin
    fmp_pkg::fmp_monitor_t m;
    m                  = '0;
    m.mode_on          = mode_on;                                 // R23
    m.boot             = st.active.boot | serial_prom_mode;       // R15
    m.area             = st.active.area;
    m.rsvd             = st.active.rsvd;
    m.romsel           = st.active.romsel;
    flash_ctrl_monitor = m;
    flash_ctrl_staging = st.staged;
    if (serial_prom_mode)
    begin
      flash_ctrl_staging[4] = 1'b1;                               // R15
    end
    flash_standby_reg  = '0;
    sys_cfg_reg3       = '0;
    sys_cfg_reg3[fmp_pkg::SYS_RAM_BIT] = st.ram_stg;
    sys_cfg_reg3[fmp_pkg::SYS_VEC_BIT] = st.vec_stg;
    // Port control is invisible in MCU mode
    port_input_ctrl    = '0;                                      // R24
    if (serial_prom_mode)
    begin
      port_input_ctrl = fmp_pkg::PORT_RD_SET;
      port_input_ctrl[fmp_pkg::PIN_GEN_BIT] = st.pin.general;
      port_input_ctrl[fmp_pkg::PIN_CLK_BIT] = st.pin.sclk;
    end
  end

  // Flash side from flip-flops
  assign flash_cmd_wr    = st.cmd_wr;
  assign flash_cmd_addr  = st.cmd_addr;
  assign flash_cmd_data  = st.cmd_data;
  assign flash_toggle_en = mode_on;                               // R3
  assign code_route      = st.code_r;
  assign data_route      = st.data_r;
  assign standby_reset   = st.stby_rst;

  // Port enables: all open in MCU mode, gated in PROM mode
  assign general_port_input_en = !serial_prom_mode ||
                                 st.pin.general;          // R20 R21 R22
  assign serial_clk_input_en   = !serial_prom_mode ||
                                 st.pin.sclk;             // R20 R21 R22

  // ==========================================================
  // Checks
  // ==========================================================
  // Enable code staged, then the key
  sequence s_stage_on;
    stage_wr && wr_data[7:5] == fmp_pkg::MODE_ON && !commit_wr;
  endsequence

  sequence s_key_only;
    commit_wr && wr_data == fmp_pkg::KEY_FLASH && !stage_wr;
  endsequence

  chk_enable_seq: assert property (@(posedge ref_clk) // R1
    disable iff (!reset_n)
    s_stage_on ##1 s_key_only |=> flash_toggle_en)
    else $error("enable sequence did not take effect");

  chk_protect_seq: assert property (@(posedge ref_clk) // R2
    disable iff (!reset_n)
    (stage_wr && wr_data[7:5] == fmp_pkg::MODE_OFF && !commit_wr)
    ##1 s_key_only |=> !flash_toggle_en)
    else $error("protect sequence did not take effect");

  chk_cmd_blocked: assert property (@(posedge ref_clk) // R3
    disable iff (!reset_n)
    (data_wr && !flash_toggle_en) |=> !flash_cmd_wr)
    else $error("command passed while protected");

  chk_reset_prot: assert property (@(posedge ref_clk) // R4
    disable iff (!reset_n)
    $rose(reset_n) |-> !flash_toggle_en &&
      flash_ctrl_staging[7:5] == fmp_pkg::MODE_OFF)
    else $error("protect field wrong after reset");

  chk_cmd_route: assert property (@(posedge ref_clk) // R9
    disable iff (!reset_n)
    (data_wr && flash_toggle_en && data_addr >= fmp_pkg::FLASH_LO)
    |=> flash_cmd_wr && flash_cmd_addr == $past(data_addr[14:0]))
    else $error("command write lost or misaddressed");

  chk_bad_key: assert property (@(posedge ref_clk) // R25
    disable iff (!reset_n)
    (commit_wr && wr_data != fmp_pkg::KEY_FLASH)
    |=> $stable(flash_ctrl_monitor[5:0]) || $past(serial_prom_mode)
        != serial_prom_mode)
    else $error("wrong key changed active settings");

  chk_ram_spm: assert property (@(posedge ref_clk) // R12
    disable iff (!reset_n)
    (serial_prom_mode && code_fetch && code_addr <= fmp_pkg::RAM_C_HI)
    |=> code_route.tgt == fmp_pkg::TGT_RAM)
    else $error("RAM not mapped in PROM mode");

  chk_boot_spm: assert property (@(posedge ref_clk) // R14
    disable iff (!reset_n)
    (serial_prom_mode && code_fetch && code_addr >= 16'h1800 &&
     code_addr <= fmp_pkg::BOOT_HI_SP)
    |=> code_route.tgt == fmp_pkg::TGT_BOOT)
    else $error("boot ROM missing in PROM mode");

  chk_stby_rst: assert property (@(posedge ref_clk) // R17
    disable iff (!reset_n)
    (st.stby && data_rd && data_addr >= fmp_pkg::FLASH_LO) ##1 !fl_acc
    |-> standby_reset ##1 !standby_reset[*1])
    else $error("standby reset not one pulse");

  chk_stby_flash: assert property (@(posedge ref_clk) // R16
    disable iff (!reset_n)
    (standby_wr && !fetch_from_ram && !irq_ack) |=> $stable(st.stby))
    else $error("standby written from flash");

  chk_irq_clear: assert property (@(posedge ref_clk) // R18
    disable iff (!reset_n)
    (irq_ack && !st.vec_act) |=> !st.stby)
    else $error("standby not cleared on interrupt");

  chk_port_mcu: assert property (@(posedge ref_clk) // R22
    disable iff (!reset_n)
    !serial_prom_mode |-> port_input_ctrl == 8'h00 &&
      general_port_input_en && serial_clk_input_en)
    else $error("port control active in MCU mode");

endmodule

// ===== test/fmp_cpu_model.sv
// CPU core model: register writes, memory accesses and interrupt acks
`timescale 1ns/1ns
module fmp_cpu_model
(
  // Clock
  input  wire logic  ref_clk,
  // Register write strobes and shared data
  output logic       stage_wr,
  output logic       commit_wr,
  output logic       sys_cfg_wr,
  output logic       sys_commit_wr,
  output logic       standby_wr,
  output logic       port_ctrl_wr,
  output logic [7:0] wr_data,
  // Memory accesses
  output logic        code_fetch,
  output logic [15:0] code_addr,
  output logic        data_rd,
  output logic        data_wr,
  output logic [15:0] data_addr,
  output logic [7:0]  data_wdata,
  output logic        irq_ack
);
  // ==========================================
  // Strobe vector, one bit per register
  // ==========================================
  logic [5:0] stb = 6'h00; // 0 stage .. 5 port control
  assign {port_ctrl_wr, standby_wr, sys_commit_wr, sys_cfg_wr,
          commit_wr, stage_wr} = stb;
  // Idle values at time zero
  initial
  begin
    wr_data = 8'h00;
    {code_fetch, data_rd, data_wr, irq_ack} = 4'h0;
    {code_addr, data_addr, data_wdata} = 40'h0;
  end
  // One register write; commits here are how keys reach the block
  task automatic wreg(input int r, input logic [7:0] d);
    @(negedge ref_clk);
    stb[r] = 1'b1;
    wr_data = d;
    @(negedge ref_clk);
    stb = 6'h00;
    wr_data = ~d; // Released bus must not keep the last value
  endtask
  // One access: 0 fetch, 1 read, 2 write
  task automatic acc(input int k, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge ref_clk);
    code_fetch = (k == 0);
    data_rd = (k == 1);
    data_wr = (k == 2);
    {code_addr, data_addr, data_wdata} = {a, a, d};
    @(negedge ref_clk);
    {code_fetch, data_rd, data_wr} = 3'h0;
    {code_addr, data_addr, data_wdata} = {~a, ~a, ~d};
  endtask
  // Interrupt taken, one cycle
  task automatic irq();
    @(negedge ref_clk);
    irq_ack = 1'b1;
    @(negedge ref_clk);
    irq_ack = 1'b0;
  endtask
endmodule

// ===== test/test_fmp_flash_map_ctrl.sv
// Testbench: flash map and protect control driven by a CPU model
`timescale 1ns/1ns
module test_fmp_flash_map_ctrl;
  // ==========================================
  // Signals
  // ==========================================
  logic ref_clk = 1'b0; // 4 ns period
  logic reset_n = 1'b0; // Low from time zero
  logic serial_prom_mode = 1'b0; // Mode strap
  logic fetch_from_ram = 1'b0; // Storing code source
  logic stage_wr, commit_wr, sys_cfg_wr, sys_commit_wr;
  logic standby_wr, port_ctrl_wr, code_fetch, data_rd, data_wr, irq_ack;
  logic [7:0] wr_data, data_wdata, flash_cmd_data;
  logic [15:0] code_addr, data_addr;
  logic [7:0] flash_ctrl_staging, flash_ctrl_monitor, flash_standby_reg;
  logic [7:0] sys_cfg_reg3, port_input_ctrl;
  logic flash_cmd_wr, flash_toggle_en, standby_reset;
  logic general_port_input_en, serial_clk_input_en;
  logic [14:0] flash_cmd_addr;
  fmp_pkg::fmp_route_t code_route, data_route;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h922c644d; // Fixed, so runs repeat
  localparam logic [7:0] KF = fmp_pkg::KEY_FLASH;
  localparam logic [7:0] KS = fmp_pkg::KEY_SYS;
  always #2 ref_clk = ~ref_clk;
  // ==========================================
  // Design and CPU model
  // ==========================================
  fmp_flash_map_ctrl dut
  (
    .ref_clk, .reset_n, .serial_prom_mode, .stage_wr, .commit_wr,
    .sys_cfg_wr, .sys_commit_wr, .standby_wr, .port_ctrl_wr, .wr_data,
    .fetch_from_ram, .flash_ctrl_staging, .flash_ctrl_monitor,
    .flash_standby_reg, .sys_cfg_reg3, .port_input_ctrl, .code_fetch,
    .code_addr, .data_rd, .data_wr, .data_addr, .data_wdata, .irq_ack,
    .flash_cmd_wr, .flash_cmd_addr, .flash_cmd_data, .flash_toggle_en,
    .code_route, .data_route, .standby_reset, .general_port_input_en,
    .serial_clk_input_en
  );
  fmp_cpu_model cpu
  (
    .ref_clk, .stage_wr, .commit_wr, .sys_cfg_wr, .sys_commit_wr,
    .standby_wr, .port_ctrl_wr, .wr_data, .code_fetch, .code_addr,
    .data_rd, .data_wr, .data_addr, .data_wdata, .irq_ack
  );
  // ==========================================
  // Helpers
  // ==========================================
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected target of one address under the given map
  function automatic fmp_pkg::fmp_target_t exp_tgt(input logic [15:0] a,
    input logic code, input logic boot, input logic ram);
    logic [15:0] hi;
    hi = (code && serial_prom_mode) ? fmp_pkg::BOOT_HI_SP : fmp_pkg::BOOT_HI;
    if ((boot || serial_prom_mode) && a >= fmp_pkg::BOOT_LO && a <= hi)
      return fmp_pkg::TGT_BOOT;
    if (code && (ram || serial_prom_mode) && a <= fmp_pkg::RAM_C_HI)
      return fmp_pkg::TGT_RAM;
    if (a >= fmp_pkg::FLASH_LO)
      return fmp_pkg::TGT_FLASH;
    return fmp_pkg::TGT_NONE;
  endfunction
  task automatic chk(input logic [23:0] g, input logic [23:0] e,
                     input string m);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Access then compare the route that it produced
  task automatic probe(input int k, input logic [15:0] a,
                       input logic b, input logic r);
    fmp_pkg::fmp_target_t e;
    fmp_pkg::fmp_route_t  g;
    e = exp_tgt(a, k == 0, b, r);
    cpu.acc(k, a, 8'h00);
    g = (k == 0) ? code_route : data_route;
    chk(g.tgt, e, "route target");
    if (e == fmp_pkg::TGT_FLASH)
      chk(g.flash_off, a[14:0], "flash offset");
  endtask
  task automatic rst();
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, about 25 times the run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      wrap_up();
    end
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial
  begin
    logic [31:0] r;
    logic [7:0]  k;
    rst();
    chk(flash_ctrl_staging, 8'h40, "staging reset");
    chk(flash_toggle_en, 1'b0, "toggle reset");
    cpu.wreg(5, 8'h03);
    chk(port_input_ctrl, 8'h00, "port ctrl mcu");
    chk({general_port_input_en, serial_clk_input_en}, 2'b11, "mcu");
    cpu.acc(2, 16'hf555, 8'haa);
    chk(flash_cmd_wr, 1'b0, "protected cmd");
    cpu.wreg(0, 8'ha0);
    chk(flash_toggle_en, 1'b0, "staged only");
    r = xs();
    k = (r[7:0] == KF) ? 8'h00 : r[7:0];
    cpu.wreg(1, k);
    chk(flash_toggle_en, 1'b0, "bad key");
    cpu.wreg(1, KF);
    chk(flash_ctrl_monitor, 8'h20, "enabled");
    repeat (8)
    begin
      r = xs();
      cpu.acc(2, {1'b1, r[14:0]}, r[23:16]);
      chk(flash_cmd_wr, 1'b1, "cmd pass");
      chk({flash_cmd_addr, flash_cmd_data}, {r[14:0], r[23:16]}, "cmd");
    end
    cpu.acc(2, 16'h4555, 8'haa);
    chk(flash_cmd_wr, 1'b0, "cmd outside data window");
    cpu.wreg(0, 8'ha8);
    cpu.wreg(1, KF);
    chk(flash_ctrl_monitor, 8'h28, "area code");
    probe(0, 16'h9234, 0, 0);
    probe(1, 16'h9234, 0, 0);
    cpu.wreg(0, 8'ha0);
    cpu.wreg(1, KF);
    chk(flash_ctrl_monitor, 8'h20, "area std");
    cpu.wreg(0, 8'h40);
    cpu.wreg(1, KF);
    chk(flash_toggle_en, 1'b0, "protect");
    cpu.acc(2, 16'hf555, 8'haa);
    chk(flash_cmd_wr, 1'b0, "cmd after protect");
    cpu.wreg(2, 8'h01);
    cpu.wreg(3, KF);
    cpu.acc(0, 16'h0100, 8'h00);
    chk(code_route.tgt == fmp_pkg::TGT_RAM, 1'b0, "ram bad key");
    cpu.wreg(3, KS);
    probe(0, 16'h0100, 0, 1);
    cpu.wreg(2, 8'h00);
    cpu.wreg(3, KS);
    cpu.acc(0, 16'h0100, 8'h00);
    chk(code_route.tgt == fmp_pkg::TGT_RAM, 1'b0, "ram off");
    cpu.wreg(0, 8'h50);
    cpu.wreg(1, KF);
    probe(1, 16'h1000, 1, 0);
    probe(0, 16'h17ff, 1, 0);
    probe(0, 16'h1800, 1, 0);
    cpu.wreg(0, 8'h40);
    cpu.wreg(1, KF);
    cpu.acc(1, 16'h1000, 8'h00);
    chk(data_route.tgt == fmp_pkg::TGT_BOOT, 1'b0, "boot hidden");
    cpu.wreg(4, 8'h01);
    cpu.acc(1, 16'h9000, 8'h00);
    chk(standby_reset, 1'b0, "standby from flash");
    fetch_from_ram = 1'b1;
    cpu.wreg(4, 8'h01);
    fetch_from_ram = 1'b0;
    cpu.acc(1, 16'h9000, 8'h00);
    chk({standby_reset, flash_standby_reg}, 9'h100, "standby read");
    cpu.acc(0, 16'h8000, 8'h00);
    chk(standby_reset, 1'b1, "standby fetch");
    cpu.irq();
    cpu.acc(1, 16'h9000, 8'h00);
    chk(standby_reset, 1'b0, "irq clears");
    cpu.wreg(2, 8'h02);
    cpu.wreg(3, KS);
    fetch_from_ram = 1'b1;
    cpu.wreg(4, 8'h01);
    fetch_from_ram = 1'b0;
    cpu.irq();
    cpu.acc(0, 16'h8000, 8'h00);
    chk({standby_reset, sys_cfg_reg3}, 9'h102, "irq keeps");
    serial_prom_mode = 1'b1;
    rst();
    chk(port_input_ctrl, 8'h80, "prom port read");
    chk({general_port_input_en, serial_clk_input_en}, 2'b00, "gated");
    cpu.wreg(5, 8'h02);
    chk({general_port_input_en, serial_clk_input_en}, 2'b01, "sclk");
    cpu.wreg(5, 8'h01);
    chk({general_port_input_en, serial_clk_input_en}, 2'b10, "gen");
    probe(0, 16'h1f00, 0, 0);
    probe(1, 16'h1000, 0, 0);
    probe(0, 16'h0100, 0, 0);
    cpu.wreg(0, 8'h40);
    chk(flash_ctrl_staging, 8'h50, "boot fixed");
    cpu.wreg(1, KF);
    chk(flash_ctrl_monitor[4], 1'b1, "boot monitor");
    wrap_up();
  end
endmodule
